// ==== ccr_charger_regs.sv ====
// charger policy, event enable and event pending registers
`timescale 1ns/1ps
module ccr_charger_regs #(
    parameter logic [6:0] DEVICE_ADDR = 7'h14,
    parameter logic [2:0] SYS_VOLT_DEFAULT = 3'h0,
    parameter int CYCLES_PER_SEC = ccr_pkg::CYCLES_PER_SEC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // serial port pins
    input wire logic scl_pin,
    input wire logic sda_pin,
    output logic sda_out,
    output logic sda_oe,
    // analog comparator pins
    input wire logic sys_below_batt,
    input wire logic batt_above_weak,
    input wire logic batt_below_limit,
    // event detector pulses
    input wire logic thermal_limit_event,
    input wire logic overtemp_event,
    input wire logic thermistor_event,
    input wire logic battery_level_event,
    input wire logic charger_mode_event,
    input wire logic input_supply_event,
    // watchdog control
    input wire logic watchdog_enable,
    input wire logic watchdog_period_select,
    input wire logic watchdog_kick,
    // policy outputs
    output logic temp_compliance_enable,
    output logic temp_profile_select,
    output logic charge_voltage_limit_enable,
    output logic [1:0] ideal_diode_mode,
    output logic [2:0] system_voltage_code,
    output logic [12:0] system_voltage_mv,
    output logic ideal_diode_conduct,
    output logic charge_inhibit,
    // watchdog and interrupt outputs
    output logic watchdog_alarm,
    output logic watchdog_expired,
    output logic irq_request
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [6:0] wd_limit(input logic long_sel);
        return long_sel ? ccr_pkg::WD_LONG_S : ccr_pkg::WD_SHORT_S;
    endfunction

    function automatic logic [6:0] wd_lead(input logic long_sel);
        return long_sel ? ccr_pkg::WD_LONG_LEAD_S : ccr_pkg::WD_SHORT_LEAD_S;
    endfunction

    function automatic logic [12:0] sys_mv(input logic [2:0] code);
        return ccr_pkg::SYS_MV_BASE + 13'(code) * ccr_pkg::SYS_MV_STEP;
    endfunction

    localparam logic [12:0] SYS_MV_RESET = ccr_pkg::SYS_MV_BASE
        + 13'(SYS_VOLT_DEFAULT) * ccr_pkg::SYS_MV_STEP;

    // ------------------------------------------------------------
    // serial port
    // ------------------------------------------------------------
    logic [7:0] reg_ptr;
    logic wr_stb;
    logic [7:0] wr_data;
    logic rd_stb;
    logic [7:0] rd_data;

    ccr_i2c_slave #(
        .DEVICE_ADDR(DEVICE_ADDR)
    ) u_port (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .scl_pin(scl_pin),
        .sda_pin(sda_pin),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .reg_ptr(reg_ptr),
        .wr_stb(wr_stb),
        .wr_data(wr_data),
        .rd_stb(rd_stb),
        .rd_data(rd_data)
    );

    // ------------------------------------------------------------
    // register state and decode
    // ------------------------------------------------------------
    ccr_pkg::ccr_policy_t policy;
    logic [6:0] enable;
    logic [6:0] flags;

    wire hit_policy = reg_ptr == ccr_pkg::ADDR_CHARGE_POLICY;
    wire hit_enable = reg_ptr == ccr_pkg::ADDR_EVENT_ENABLE;
    wire hit_pending = reg_ptr == ccr_pkg::ADDR_EVENT_PENDING;
    wire wr_policy = wr_stb && hit_policy;
    wire wr_enable = wr_stb && hit_enable;
    wire rd_clear = rd_stb && hit_pending;

    // bit 7 of the enable and pending registers reads zero
    assign rd_data = hit_policy ? policy :
                     hit_enable ? {1'b0, enable} :
                     hit_pending ? {1'b0, flags} :
                     ccr_pkg::READ_UNMAPPED;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            policy <= {ccr_pkg::POLICY_UPPER_RESET, SYS_VOLT_DEFAULT};
        end else if (clk_en && wr_policy) begin
            policy <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            enable <= ccr_pkg::EVENT_ENABLE_RESET;
        end else if (clk_en && wr_enable) begin
            enable <= wr_data[6:0];
        end
    end

    // ------------------------------------------------------------
    // comparator synchronisers
    // ------------------------------------------------------------
    logic [2:0] cmp_s1;
    logic [2:0] cmp_s2;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cmp_s1 <= 3'h0;
            cmp_s2 <= 3'h0;
        end else if (clk_en) begin
            cmp_s1 <= {sys_below_batt, batt_above_weak, batt_below_limit};
            cmp_s2 <= cmp_s1;
        end
    end

    wire diode_on = (policy.ideal_diode_mode == ccr_pkg::DIODE_ALWAYS
                     && cmp_s2[2])
                    || (policy.ideal_diode_mode == ccr_pkg::DIODE_WEAK_GATED
                        && cmp_s2[2] && cmp_s2[1]);
    wire inhibit = policy.charge_voltage_limit_enable && !cmp_s2[0];

    // ------------------------------------------------------------
    // watchdog timer
    // ------------------------------------------------------------
    logic [31:0] presc;
    logic [6:0] sec_cnt;

    // no alarm or expiry in a cycle that stops or restarts the timer
    wire wd_run = watchdog_enable && !watchdog_kick;
    wire sec_tick = wd_run && presc == 32'(CYCLES_PER_SEC - 1);
    wire [6:0] sec_next = sec_cnt + 7'h01;
    wire wd_expire_hit = sec_tick
                         && sec_next == wd_limit(watchdog_period_select);
    wire wd_alarm_hit = sec_tick
                        && sec_next == wd_limit(watchdog_period_select)
                                       - wd_lead(watchdog_period_select);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            presc <= 32'h0000_0000;
            sec_cnt <= 7'h00;
        end else if (clk_en) begin
            if (!watchdog_enable || watchdog_kick) begin
                presc <= 32'h0000_0000;
                sec_cnt <= 7'h00;
            end else if (sec_tick) begin
                presc <= 32'h0000_0000;
                sec_cnt <= wd_expire_hit ? 7'h00 : sec_next;
            end else begin
                presc <= presc + 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------
    // event flags
    // ------------------------------------------------------------
    logic [6:0] events;
    // flags as loaded into the outgoing byte one cycle before the clear
    logic [6:0] read_snap;
    assign events[ccr_pkg::EV_THERMAL_LIMIT] = thermal_limit_event;
    assign events[ccr_pkg::EV_WATCHDOG_ALARM] = wd_alarm_hit;
    assign events[ccr_pkg::EV_OVERTEMP] = overtemp_event;
    assign events[ccr_pkg::EV_THERMISTOR] = thermistor_event;
    assign events[ccr_pkg::EV_BATTERY_LEVEL] = battery_level_event;
    assign events[ccr_pkg::EV_CHARGER_MODE] = charger_mode_event;
    assign events[ccr_pkg::EV_INPUT_SUPPLY] = input_supply_event;

    wire [6:0] set_bits = events & enable;
    wire [6:0] clr_bits = rd_clear ? read_snap : 7'h00;
    // a new event in the clearing cycle survives
    wire [6:0] next_flags = (flags & ~clr_bits) | set_bits;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            flags <= ccr_pkg::EVENT_PENDING_RESET;
            read_snap <= ccr_pkg::EVENT_PENDING_RESET;
        end else if (clk_en) begin
            flags <= next_flags;
            read_snap <= flags;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            temp_compliance_enable <= 1'b0;
            temp_profile_select <= 1'b0;
            charge_voltage_limit_enable <= 1'b0;
            ideal_diode_mode <= 2'h0;
            system_voltage_code <= SYS_VOLT_DEFAULT;
            system_voltage_mv <= SYS_MV_RESET;
            ideal_diode_conduct <= 1'b0;
            charge_inhibit <= 1'b0;
            watchdog_alarm <= 1'b0;
            watchdog_expired <= 1'b0;
            irq_request <= 1'b0;
        end else if (clk_en) begin
            temp_compliance_enable <= policy.temp_compliance_enable;
            temp_profile_select <= policy.temp_profile_select;
            charge_voltage_limit_enable <=
                policy.charge_voltage_limit_enable;
            ideal_diode_mode <= policy.ideal_diode_mode;
            system_voltage_code <= policy.system_voltage_code;
            system_voltage_mv <= sys_mv(policy.system_voltage_code);
            ideal_diode_conduct <= diode_on;
            charge_inhibit <= inhibit;
            watchdog_alarm <= wd_alarm_hit;
            watchdog_expired <= wd_expire_hit;
            irq_request <= |(flags & enable);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    sequence s_policy_wr;
        clk_en && wr_policy;
    endsequence

    sequence s_read_clear;
        clk_en && rd_clear && set_bits == 7'h00;
    endsequence

    property p_policy_wr;
        s_policy_wr |=> policy == $past(wr_data);
    endproperty
    a_policy_wr: assert property (p_policy_wr)
        else $error("policy register missed a write");

    property p_profile_out;
        s_policy_wr ##1 clk_en |=>
            temp_profile_select == $past(wr_data[6], 2);
    endproperty
    a_profile_out: assert property (p_profile_out)
        else $error("profile select output does not follow write");

    property p_inhibit;
        clk_en |=> charge_inhibit ==
            $past(policy.charge_voltage_limit_enable && !cmp_s2[0]);
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("charge inhibit wrong");

    property p_diode_weak;
        clk_en && policy.ideal_diode_mode == 2'h1 && !cmp_s2[1]
            |=> !ideal_diode_conduct;
    endproperty
    a_diode_weak: assert property (p_diode_weak)
        else $error("diode conducts on weak battery");

    property p_diode_off;
        clk_en && policy.ideal_diode_mode[1] |=> !ideal_diode_conduct;
    endproperty
    a_diode_off: assert property (p_diode_off)
        else $error("diode conducts while disabled");

    property p_sys_mv;
        clk_en |=> system_voltage_mv ==
            sys_mv($past(policy.system_voltage_code));
    endproperty
    a_sys_mv: assert property (p_sys_mv)
        else $error("system voltage value wrong");

    property p_flag_set;
        clk_en && set_bits != 7'h00 |=>
            (flags & $past(set_bits)) == $past(set_bits);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("enabled event lost");

    property p_no_spurious;
        clk_en |=> (flags & ~$past(flags) & ~$past(set_bits)) == 7'h00;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("flag set without enabled event");

    property p_wd_lead;
        watchdog_alarm && $stable(watchdog_period_select) |->
            sec_cnt + wd_lead(watchdog_period_select)
                == wd_limit(watchdog_period_select);
    endproperty
    a_wd_lead: assert property (p_wd_lead)
        else $error("watchdog alarm at wrong second");

    property p_wd_wrap;
        watchdog_expired |-> sec_cnt == 7'h00
            && $past(sec_cnt) + 7'h01 == wd_limit($past(watchdog_period_select));
    endproperty
    a_wd_wrap: assert property (p_wd_wrap)
        else $error("watchdog expiry at wrong period");

    property p_irq;
        clk_en |=> irq_request == $past(|(flags & enable));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt request wrong");

    property p_read_clear;
        s_read_clear |=> (flags & $past(read_snap)) == 7'h00;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("read flags not cleared");

endmodule // ccr_charger_regs

// ==== ccr_host.sv ====
// two-wire host model for the register port
`timescale 1ns/1ps
module ccr_host (
    // clock and wire level
    input wire logic ref_clk,
    input wire logic sda,
    // driven lines
    output logic scl = 1'b1,
    output logic sda_low = 1'b0
);
    // one bit, sampled with scl high; f adds a start or stop
    task automatic step(input logic b, input logic f, output logic r);
        repeat (6) @(negedge ref_clk);
        scl = 1'b0;
        repeat (6) @(negedge ref_clk);
        sda_low = !b;
        repeat (6) @(negedge ref_clk);
        scl = 1'b1;
        repeat (6) @(negedge ref_clk);
        r = sda;
        if (f) begin
            repeat (6) @(negedge ref_clk);
            sda_low = b;
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        logic [31:0] s;
        logic r;
        s = w ? {8'h28, a, d, 8'h00} : {8'h28, a, 8'h29, 8'hFF};
        for (int n = 0; n < 4 - w; n++) begin
            if (n == 0 || (n == 2 && !w)) begin
                step(1'b1, 1'b1, r);
            end
            for (int i = 0; i < 9; i++) begin
                step(i == 8 || s[31], 1'b0, r);
                q = (i < 8) ? {q[6:0], r} : q;
                s = (i < 8) ? s << 1 : s;
            end
        end
        step(1'b0, 1'b1, r);
    endtask
endmodule // ccr_host

// ==== ccr_i2c_slave.sv ====
// serial two-wire register port slave for the charger register bank
`timescale 1ns/1ps
module ccr_i2c_slave #(
    parameter logic [6:0] DEVICE_ADDR = 7'h14
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // serial pins
    input wire logic scl_pin,
    input wire logic sda_pin,
    output logic sda_out,
    output logic sda_oe,
    // register access
    output logic [7:0] reg_ptr,
    output logic wr_stb,
    output logic [7:0] wr_data,
    output logic rd_stb,
    input wire logic [7:0] rd_data
);

    // ------------------------------------------------------------
    // pin synchronisers and bus conditions
    // ------------------------------------------------------------
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    ccr_pkg::ccr_i2c_state_t state;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic rw;
    logic master_ack;

    wire scl_rise = scl_s[1] & ~scl_s[2];
    wire scl_fall = ~scl_s[1] & scl_s[2];
    wire start_cond = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
    wire stop_cond = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
    wire byte_done = bit_cnt == 4'h8;
    wire rx_state = state == ccr_pkg::ST_ADDR || state == ccr_pkg::ST_REG
                    || state == ccr_pkg::ST_WDATA;

    // ------------------------------------------------------------
    // byte engine
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            state <= ccr_pkg::ST_IDLE;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            rw <= 1'b0;
            master_ack <= 1'b0;
            reg_ptr <= 8'h00;
            wr_stb <= 1'b0;
            wr_data <= 8'h00;
            rd_stb <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end else if (clk_en) begin
            scl_s <= {scl_s[1:0], scl_pin};
            sda_s <= {sda_s[1:0], sda_pin};
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            sda_out <= 1'b0;
            // pointer advances after each data byte
            if (wr_stb || rd_stb) begin
                reg_ptr <= reg_ptr + 8'h01;
            end
            if (start_cond) begin
                state <= ccr_pkg::ST_ADDR;
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_cond) begin
                state <= ccr_pkg::ST_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                if (rx_state) begin
                    shift <= {shift[6:0], sda_s[1]};
                    bit_cnt <= bit_cnt + 4'h1;
                end else if (state == ccr_pkg::ST_RDATA) begin
                    bit_cnt <= bit_cnt + 4'h1;
                end else if (state == ccr_pkg::ST_RDATA_ACK) begin
                    master_ack <= ~sda_s[1];
                end
            end else if (scl_fall) begin
                case (state)
                    ccr_pkg::ST_ADDR: begin
                        if (byte_done && shift[7:1] == DEVICE_ADDR) begin
                            sda_oe <= 1'b1;
                            rw <= shift[0];
                            state <= ccr_pkg::ST_ADDR_ACK;
                        end else if (byte_done) begin
                            state <= ccr_pkg::ST_WAIT;
                        end
                    end
                    ccr_pkg::ST_REG, ccr_pkg::ST_WDATA: begin
                        if (byte_done) begin
                            sda_oe <= 1'b1;
                            if (state == ccr_pkg::ST_REG) begin
                                reg_ptr <= shift;
                                state <= ccr_pkg::ST_REG_ACK;
                            end else begin
                                wr_stb <= 1'b1;
                                wr_data <= shift;
                                state <= ccr_pkg::ST_WDATA_ACK;
                            end
                        end
                    end
                    ccr_pkg::ST_REG_ACK, ccr_pkg::ST_WDATA_ACK: begin
                        sda_oe <= 1'b0;
                        bit_cnt <= 4'h0;
                        state <= ccr_pkg::ST_WDATA;
                    end
                    ccr_pkg::ST_ADDR_ACK, ccr_pkg::ST_RDATA_ACK: begin
                        bit_cnt <= 4'h0;
                        sda_oe <= 1'b0;
                        if (state == ccr_pkg::ST_ADDR_ACK && !rw) begin
                            state <= ccr_pkg::ST_REG;
                        end else if (state == ccr_pkg::ST_RDATA_ACK
                                     && !master_ack) begin
                            state <= ccr_pkg::ST_WAIT;
                        end else begin
                            rd_stb <= 1'b1;
                            sda_oe <= ~rd_data[7];
                            shift <= {rd_data[6:0], 1'b0};
                            state <= ccr_pkg::ST_RDATA;
                        end
                    end
                    ccr_pkg::ST_RDATA: begin
                        if (byte_done) begin
                            sda_oe <= 1'b0;
                            state <= ccr_pkg::ST_RDATA_ACK;
                        end else begin
                            sda_oe <= ~shift[7];
                            shift <= {shift[6:0], 1'b0};
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

endmodule // ccr_i2c_slave

// ==== ccr_pkg.sv ====
// constants and types shared by the charger register bank
package ccr_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CHARGE_POLICY = 8'h08;
    localparam logic [7:0] ADDR_EVENT_ENABLE = 8'h09;
    localparam logic [7:0] ADDR_EVENT_PENDING = 8'h0A;

    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [4:0] POLICY_UPPER_RESET = 5'h00;
    localparam logic [6:0] EVENT_ENABLE_RESET = 7'h00;
    localparam logic [6:0] EVENT_PENDING_RESET = 7'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam int EV_THERMAL_LIMIT = 6;
    localparam int EV_WATCHDOG_ALARM = 5;
    localparam int EV_OVERTEMP = 4;
    localparam int EV_THERMISTOR = 3;
    localparam int EV_BATTERY_LEVEL = 2;
    localparam int EV_CHARGER_MODE = 1;
    localparam int EV_INPUT_SUPPLY = 0;

    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] DIODE_ALWAYS = 2'h0;
    localparam logic [1:0] DIODE_WEAK_GATED = 2'h1;
    localparam logic [12:0] SYS_MV_BASE = 13'h10CC;
    localparam logic [12:0] SYS_MV_STEP = 13'h0064;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int CYCLES_PER_SEC = CLK_HZ * 1;
    localparam logic [6:0] WD_SHORT_S = 7'h20;
    localparam logic [6:0] WD_LONG_S = 7'h40;
    localparam logic [6:0] WD_SHORT_LEAD_S = 7'h02;
    localparam logic [6:0] WD_LONG_LEAD_S = 7'h04;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic temp_compliance_enable;
        logic temp_profile_select;
        logic charge_voltage_limit_enable;
        logic [1:0] ideal_diode_mode;
        logic [2:0] system_voltage_code;
    } ccr_policy_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_WAIT
    } ccr_i2c_state_t;

endpackage

// ==== tb_top.sv ====
// self-checking bench for the charger register bank
`timescale 1ns/1ps
`define CHK(n, x, y) begin n_checks++; if ((y) !== (x)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", n, x, y); end end
module tb_top;
    logic ref_clk = 1'b0, reset = 1'b1, scl, sda_low, sda_oe, irq_request;
    logic watchdog_enable = 1'b0, watchdog_period_select = 1'b0;
    logic ideal_diode_conduct, charge_inhibit, watchdog_alarm, sda_out;
    logic watchdog_expired;
    logic [2:0] cmp = 3'h0;
    logic [5:0] ev = 6'h00;
    logic [7:0] q, v, m, e;
    wire [7:0] pol;
    logic [12:0] system_voltage_mv;
    logic [31:0] rs = 32'h76AE;
    int n_errors = 0, n_checks = 0, cyc = 0, t;
    // pulled-up line: low while the host or a driven device zero pulls it
    wire sda = !(sda_low | (sda_oe & !sda_out));
    ccr_host h (.ref_clk, .sda, .scl, .sda_low);
    ccr_charger_regs #(.CYCLES_PER_SEC(20)) uut (
        .ref_clk, .reset, .clk_en(1'b1), .scl_pin(scl), .sda_pin(sda),
        .sda_out, .sda_oe, .sys_below_batt(cmp[0]),
        .batt_above_weak(cmp[1]), .batt_below_limit(cmp[2]),
        .thermal_limit_event(ev[5]), .overtemp_event(ev[4]),
        .thermistor_event(ev[3]), .battery_level_event(ev[2]),
        .charger_mode_event(ev[1]), .input_supply_event(ev[0]),
        .watchdog_enable, .watchdog_period_select, .watchdog_kick(1'b0),
        .temp_compliance_enable(pol[7]), .temp_profile_select(pol[6]),
        .charge_voltage_limit_enable(pol[5]), .ideal_diode_mode(pol[4:3]),
        .system_voltage_code(pol[2:0]), .system_voltage_mv,
        .ideal_diode_conduct, .charge_inhibit, .watchdog_alarm,
        .watchdog_expired, .irq_request);
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [12:0] exp_mv(input logic [2:0] c);
        return 13'h10CC + 13'h0064 * 13'(c);
    endfunction
    function automatic logic exp_diode(input logic [1:0] md,
                                       input logic [2:0] c);
        return !md[1] & c[0] & (c[1] | !md[0]);
    endfunction
    function automatic logic [7:0] exp_pending(input logic [7:0] en,
                                               input logic [5:0] src);
        return {1'b0, en[6] & src[5], 1'b0, en[4:0] & src[4:0]};
    endfunction
    task automatic summarize;
        $display("errors %0d of %0d checks", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        repeat (10) @(negedge ref_clk);
        reset = 1'b0;
        for (int a = 8; a < 12; a++) begin
            h.acc(1'b0, a[7:0], 8'h00, q);
            `CHK("reset", 8'h00, q)
        end
        for (int i = 0; i < 4; i++) begin
            rs = xs(rs);
            v = {rs[7:5], i[1:0], rs[2:0]};
            cmp = rs[10:8];
            h.acc(1'b1, 8'h08, v, q);
            h.acc(1'b0, 8'h08, 8'h00, q);
            `CHK("policy", v, q)
            `CHK("fields", v, pol)
            `CHK("mv", exp_mv(v[2:0]), system_voltage_mv)
            `CHK("diode", exp_diode(v[4:3], cmp),
                ideal_diode_conduct)
            `CHK("inhibit", v[5] & !cmp[2], charge_inhibit)
        end
        for (int k = 0; k < 4; k++) begin
            rs = xs(rs);
            m = (k == 0) ? 8'h7F : {1'b0, rs[6:0]};
            v = {2'h0, (k == 0) ? 6'h3F : rs[13:8]};
            e = exp_pending(m, v[5:0]);
            h.acc(1'b1, 8'h09, m | 8'h80, q);
            h.acc(1'b0, 8'h09, 8'h00, q);
            `CHK("enable", m, q)
            ev = v[5:0];
            @(negedge ref_clk);
            ev = 6'h00;
            repeat (3) @(negedge ref_clk);
            `CHK("irq", |e, irq_request)
            h.acc(1'b0, 8'h0A, 8'h00, q);
            `CHK("pending", e, q)
            h.acc(1'b1, 8'h0A, 8'h7F, q);
            h.acc(1'b0, 8'h0A, 8'h00, q);
            `CHK("cleared", 8'h00, q)
            `CHK("irq low", 1'b0, irq_request)
        end
        h.acc(1'b1, 8'h09, 8'h20, q);
        for (int s = 0; s < 2; s++) begin
            watchdog_period_select = s[0];
            watchdog_enable = 1'b1;
            t = 0;
            while (watchdog_alarm !== 1'b1 && t < 3000) begin
                @(negedge ref_clk);
                t++;
            end
            t = t - 20 * (s ? 60 : 30);
            `CHK("alarm", 1'b1, t inside {[-3:3]})
            t = 0;
            while (watchdog_expired !== 1'b1 && t < 200) begin
                @(negedge ref_clk);
                t++;
            end
            watchdog_enable = 1'b0;
            `CHK("expiry", 20 * (s ? 4 : 2), t)
            h.acc(1'b0, 8'h0A, 8'h00, q);
            `CHK("wd flag", 8'h20, q)
        end
        summarize();
    end
endmodule // tb_top
